// *** core/ipb_pkg.sv ***
//------------------------------------------------------------------------------
// Notes on behaviour
// - Merge streams onto bus channel by channel.
// - Speed field selects rate and stream count.
// - Position field selects slot, first to eighth.
// - Every transceiver gets its own distinct position.
// - Enable bit switches interleaved bus on.
// - Bit six picks pin or backplane transmit clock.
// - Elastic stores enabled before interleaving.
// - No external transmit sync while interleaving.
// - Software writes zero to bit seven.
//------------------------------------------------------------------------------
package ipb_pkg;

  // Device register map and field layout.
  localparam logic [7:0] IPB_CFG_ADDR = 8'h1C;
  localparam logic [7:0] IPB_CFG_RESET = 8'h00;
  localparam int IPB_RSVD_BIT = 7;
  localparam int IPB_TCS_BIT = 6;
  localparam int IPB_SPEED_HI = 5;
  localparam int IPB_SPEED_LO = 4;
  localparam int IPB_EN_BIT = 3;
  localparam int IPB_POS_HI = 2;
  localparam int IPB_POS_LO = 0;

  // Frame structure and rates.
  localparam int IPB_BITS_PER_CHAN = 8;
  localparam int IPB_CHANS = 32;
  localparam int IPB_CLK_KHZ = 125000;
  localparam int IPB_BASE_KHZ = 2048;

  // Controller register map and fields.
  localparam logic [7:0] IPB_HOST_CTRL = 8'h00;
  localparam logic [7:0] IPB_HOST_DEV_WRITE = 8'h04;
  localparam logic [7:0] IPB_HOST_DEV_READ = 8'h08;
  localparam logic [7:0] IPB_HOST_STATUS = 8'h0C;
  localparam logic [2:0] IPB_HOST_CTRL_RESET = 3'h0;
  localparam int IPB_CTRL_RUN = 0;
  localparam int IPB_CTRL_ES_OK = 1;
  localparam int IPB_CTRL_TSYNC = 2;
  localparam int IPB_ST_REFUSED = 0;
  localparam int IPB_ST_RD_VALID = 1;
  localparam int IPB_ST_RD_BUSY = 2;

  typedef logic [7:0] ipb_byte_t;
  typedef logic [4:0] ipb_chan_t;
  typedef logic [1:0] ipb_speed_t;
  typedef logic [10:0] ipb_idx_t;
  typedef logic [15:0] ipb_word_t;

  function automatic logic [2:0] ipb_stream_mask(input ipb_speed_t s);
    return 3'((1 << s) - 1);
  endfunction

  function automatic ipb_idx_t ipb_frame_last(input ipb_speed_t s);
    return 11'(((IPB_CHANS * IPB_BITS_PER_CHAN) << s) - 1);
  endfunction

  function automatic ipb_chan_t ipb_chan_of(input ipb_idx_t idx, input ipb_speed_t s);
    return 5'(idx[10:3] >> s);
  endfunction

  // Disabled interleave behaves as one stream in the first position.
  function automatic ipb_speed_t ipb_eff_speed(input ipb_byte_t cfg);
    return cfg[IPB_EN_BIT] ? cfg[IPB_SPEED_HI:IPB_SPEED_LO] : 2'h0;
  endfunction

endpackage

// *** core/ipb_if.sv ***
`timescale 1ns/1ps
interface ipb_if;
  logic [7:0] dev_addr;
  logic [7:0] dev_wdata;
  logic dev_wr;
  logic dev_rd;
  logic [7:0] dev_rdata;
  logic bus_bit_en;
  logic bus_frame_sync;
  logic tx_bus_data;
  logic rx_bus_data;
  logic rx_bus_oe;
  logic rx_bus_level;
  logic host_tsync_out;
  logic host_tsync_oe;
  logic dev_tsync_out;
  logic dev_tsync_oe;
  logic tsync_level;

  // An undriven bus slot reads low; an undriven sync pin is tied to ground.
  assign rx_bus_level = rx_bus_oe ? rx_bus_data : 1'b0;
  assign tsync_level = dev_tsync_oe ? dev_tsync_out : (host_tsync_oe ? host_tsync_out : 1'b0);

  modport device (
    input dev_addr, dev_wdata, dev_wr, dev_rd, bus_bit_en, bus_frame_sync, tx_bus_data,
    input tsync_level,
    output dev_rdata, rx_bus_data, rx_bus_oe, dev_tsync_out, dev_tsync_oe
  );

  modport host (
    output dev_addr, dev_wdata, dev_wr, dev_rd, bus_bit_en, bus_frame_sync, tx_bus_data,
    output host_tsync_out, host_tsync_oe,
    input dev_rdata, rx_bus_level, rx_bus_oe
  );
endinterface // ipb_if

// *** core/ipb_device_end.sv ***
`timescale 1ns/1ps
module ipb_device_end (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Backplane link
  ipb_if.device link,
  // Receive stream from the elastic store
  input wire ipb_pkg::ipb_byte_t rx_pcm_byte,
  output ipb_pkg::ipb_chan_t rx_pcm_chan,
  // Transmit stream toward the framer
  output ipb_pkg::ipb_byte_t tx_pcm_byte,
  output ipb_pkg::ipb_chan_t tx_pcm_chan,
  output logic tx_pcm_valid,
  output logic tx_frame_start,
  // Transmit clock
  input wire logic tx_line_clk_pin,
  output logic tx_clk_en,
  // Status
  output logic interleave_active
);
  import ipb_pkg::*;

  //----------------------------------------------------------------------------
  // Register access
  //----------------------------------------------------------------------------
  ipb_byte_t cfg_r, cfg_nxt;
  ipb_byte_t rdata_r, rdata_nxt;

  always_comb begin
    cfg_nxt = cfg_r;
    rdata_nxt = 8'h00;
    if (link.dev_wr && link.dev_addr == IPB_CFG_ADDR) begin
      // The unassigned top bit is not stored and reads as zero.
      cfg_nxt = {1'b0, link.dev_wdata[IPB_TCS_BIT:0]};
    end
    if (link.dev_rd) begin
      if (link.dev_addr == IPB_CFG_ADDR) begin
        rdata_nxt = cfg_r;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_r <= IPB_CFG_RESET;
      rdata_r <= 8'h00;
    end else begin
      cfg_r <= cfg_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  //----------------------------------------------------------------------------
  // Shared bus slots
  //----------------------------------------------------------------------------
  logic enable;
  ipb_speed_t speed;
  logic [2:0] pos;
  logic [2:0] mask;
  ipb_idx_t cnt_r, cnt_nxt;
  logic own_r, own_nxt;
  ipb_byte_t rx_shift_r, rx_shift_nxt;
  ipb_byte_t tx_shift_r, tx_shift_nxt;
  ipb_chan_t rx_chan_r, rx_chan_nxt;
  ipb_byte_t tx_byte_r, tx_byte_nxt;
  ipb_chan_t tx_chan_r, tx_chan_nxt;
  logic tx_valid_r, tx_valid_nxt;
  logic bus_data_r, bus_data_nxt;
  logic bus_oe_r, bus_oe_nxt;

  assign enable = cfg_r[IPB_EN_BIT];
  assign speed = ipb_eff_speed(cfg_r);
  assign pos = enable ? cfg_r[IPB_POS_HI:IPB_POS_LO] : 3'h0;
  assign mask = ipb_stream_mask(speed);

  always_comb begin
    cnt_nxt = cnt_r;
    own_nxt = own_r;
    rx_shift_nxt = rx_shift_r;
    tx_shift_nxt = tx_shift_r;
    rx_chan_nxt = rx_chan_r;
    tx_byte_nxt = tx_byte_r;
    tx_chan_nxt = tx_chan_r;
    tx_valid_nxt = 1'b0;
    bus_data_nxt = bus_data_r;
    bus_oe_nxt = bus_oe_r;
    if (link.bus_bit_en) begin
      // Sample the bit that has just ended.
      if (own_r) begin
        tx_shift_nxt = {tx_shift_r[6:0], link.tx_bus_data};
        if (cnt_r[2:0] == 3'h7) begin
          tx_byte_nxt = {tx_shift_r[6:0], link.tx_bus_data};
          tx_chan_nxt = ipb_chan_of(cnt_r, speed);
          tx_valid_nxt = 1'b1;
        end
      end
      if (link.bus_frame_sync || cnt_r >= ipb_frame_last(speed)) begin
        cnt_nxt = 11'h000;
      end else begin
        cnt_nxt = 11'(cnt_r + 11'h001);
      end
      // Slots of eight bits rotate through the streams, one channel each.
      own_nxt = ((cnt_nxt[5:3] & mask) == pos);
      bus_oe_nxt = own_nxt;
      if (!own_nxt) begin
        bus_data_nxt = 1'b0;
      end else if (cnt_nxt[2:0] == 3'h0) begin
        bus_data_nxt = rx_pcm_byte[7];
        rx_shift_nxt = {rx_pcm_byte[6:0], 1'b0};
        // Point the user at the channel for our next slot; this resyncs each frame.
        rx_chan_nxt = 5'(ipb_chan_of(cnt_nxt, speed) + 5'h01);
      end else begin
        bus_data_nxt = rx_shift_r[7];
        rx_shift_nxt = {rx_shift_r[6:0], 1'b0};
      end
    end
    if (link.dev_wr && link.dev_addr == IPB_CFG_ADDR) begin
      own_nxt = 1'b0;
      rx_chan_nxt = 5'h00;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r <= 11'h000;
      own_r <= 1'b0;
      rx_shift_r <= 8'h00;
      tx_shift_r <= 8'h00;
      rx_chan_r <= 5'h00;
      tx_byte_r <= 8'h00;
      tx_chan_r <= 5'h00;
      tx_valid_r <= 1'b0;
      bus_data_r <= 1'b0;
      bus_oe_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      own_r <= own_nxt;
      rx_shift_r <= rx_shift_nxt;
      tx_shift_r <= tx_shift_nxt;
      rx_chan_r <= rx_chan_nxt;
      tx_byte_r <= tx_byte_nxt;
      tx_chan_r <= tx_chan_nxt;
      tx_valid_r <= tx_valid_nxt;
      bus_data_r <= bus_data_nxt;
      bus_oe_r <= bus_oe_nxt;
    end
  end

  //----------------------------------------------------------------------------
  // Transmit clock and frame sync
  //----------------------------------------------------------------------------
  logic pin_s1_r, pin_s2_r, pin_s3_r;
  logic pin_filt_r, pin_filt_nxt;
  logic [2:0] div_r, div_nxt;
  logic transmit_line_clock_pin_r, transmit_line_clock_pin_nxt;
  logic tsync_out_r, tsync_out_nxt;
  logic tsync_oe_r, tsync_oe_nxt;
  logic fstart_r, fstart_nxt;

  always_comb begin
    pin_filt_nxt = pin_filt_r;
    div_nxt = div_r;
    transmit_line_clock_pin_nxt = 1'b0;
    if (pin_s2_r == pin_s3_r) begin
      pin_filt_nxt = pin_s3_r;
    end
    if (link.bus_bit_en) begin
      div_nxt = (div_r >= mask) ? 3'h0 : 3'(div_r + 3'h1);
    end
    if (cfg_r[IPB_TCS_BIT]) begin
      // One pulse per stream count of bus bits gives the base line rate.
      transmit_line_clock_pin_nxt = link.bus_bit_en && (div_r == 3'h0);
    end else begin
      transmit_line_clock_pin_nxt = (pin_s2_r == pin_s3_r) && pin_s3_r && !pin_filt_r;
    end
    // While interleaving, the sync pin is ours; any external drive is ignored.
    tsync_oe_nxt = enable;
    tsync_out_nxt = enable && link.bus_bit_en && link.bus_frame_sync;
    fstart_nxt = enable ? (link.bus_bit_en && link.bus_frame_sync) : link.tsync_level;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
      pin_filt_r <= 1'b0;
      div_r <= 3'h0;
      transmit_line_clock_pin_r <= 1'b0;
      tsync_out_r <= 1'b0;
      tsync_oe_r <= 1'b0;
      fstart_r <= 1'b0;
    end else begin
      pin_s1_r <= tx_line_clk_pin;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_filt_r <= pin_filt_nxt;
      div_r <= div_nxt;
      transmit_line_clock_pin_r <= transmit_line_clock_pin_nxt;
      tsync_out_r <= tsync_out_nxt;
      tsync_oe_r <= tsync_oe_nxt;
      fstart_r <= fstart_nxt;
    end
  end

  assign link.dev_rdata = rdata_r;
  assign link.rx_bus_data = bus_data_r;
  assign link.rx_bus_oe = bus_oe_r;
  assign link.dev_tsync_out = tsync_out_r;
  assign link.dev_tsync_oe = tsync_oe_r;
  assign rx_pcm_chan = rx_chan_r;
  assign tx_pcm_byte = tx_byte_r;
  assign tx_pcm_chan = tx_chan_r;
  assign tx_pcm_valid = tx_valid_r;
  assign tx_frame_start = fstart_r;
  assign tx_clk_en = transmit_line_clock_pin_r;
  assign interleave_active = cfg_r[IPB_EN_BIT];

endmodule // ipb_device_end

// *** core/ipb_host_end.sv ***
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module ipb_host_end (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Backplane link
  ipb_if.host link,
  // Software port
  input wire logic [7:0] sw_addr,
  input wire ipb_pkg::ipb_word_t sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output ipb_pkg::ipb_word_t sw_rdata,
  // Backplane user side
  input wire ipb_pkg::ipb_byte_t bp_tx_byte,
  output logic [7:0] bp_tx_slot,
  output ipb_pkg::ipb_byte_t bp_rx_byte,
  output logic [7:0] bp_rx_slot,
  output logic bp_rx_valid,
  output logic bp_frame_start
);
  import ipb_pkg::*;

  //----------------------------------------------------------------------------
  // Software registers and device access
  //----------------------------------------------------------------------------
  logic [2:0] ctrl_r, ctrl_nxt;
  ipb_byte_t shadow_r, shadow_nxt;
  logic refused_r, refused_nxt;
  ipb_byte_t rd_data_r, rd_data_nxt;
  logic rd_valid_r, rd_valid_nxt;
  logic rd_busy_r, rd_busy_nxt;
  ipb_word_t sw_rdata_r, sw_rdata_nxt;
  logic [7:0] dev_addr_r, dev_addr_nxt;
  ipb_byte_t dev_wdata_r, dev_wdata_nxt;
  logic dev_wr_r, dev_wr_nxt;
  logic dev_rd_r, dev_rd_nxt;
  ipb_byte_t cand;
  logic refuse;

  always_comb begin
    ctrl_nxt = ctrl_r;
    shadow_nxt = shadow_r;
    rd_data_nxt = rd_data_r;
    rd_valid_nxt = rd_valid_r;
    rd_busy_nxt = dev_rd_r;
    sw_rdata_nxt = 16'h0000;
    dev_addr_nxt = dev_addr_r;
    dev_wdata_nxt = dev_wdata_r;
    dev_wr_nxt = 1'b0;
    dev_rd_nxt = 1'b0;
    refuse = 1'b0;
    cand = sw_wdata[7:0];
    if (sw_wdata[15:8] == IPB_CFG_ADDR) begin
      cand[IPB_RSVD_BIT] = 1'b0;
    end
    if (rd_busy_r && !dev_rd_r) begin
      rd_data_nxt = link.dev_rdata;
      rd_valid_nxt = 1'b1;
    end
    if (sw_wr) begin
      if (sw_addr == IPB_HOST_CTRL) begin
        ctrl_nxt = sw_wdata[2:0];
      end else if (sw_addr == IPB_HOST_DEV_WRITE) begin
        if (sw_wdata[15:8] == IPB_CFG_ADDR && cand[IPB_EN_BIT]) begin
          // Interleaving needs the elastic stores on and a slot inside the bus.
          refuse = !ctrl_r[IPB_CTRL_ES_OK] ||
            ((cand[IPB_POS_HI:IPB_POS_LO] & ~ipb_stream_mask(ipb_eff_speed(cand))) != 3'h0);
        end
        if (!refuse) begin
          dev_addr_nxt = sw_wdata[15:8];
          dev_wdata_nxt = cand;
          dev_wr_nxt = 1'b1;
          if (sw_wdata[15:8] == IPB_CFG_ADDR) begin
            shadow_nxt = cand;
          end
        end
      end else if (sw_addr == IPB_HOST_DEV_READ) begin
        dev_addr_nxt = sw_wdata[15:8];
        dev_rd_nxt = 1'b1;
        rd_busy_nxt = 1'b1;
        rd_valid_nxt = 1'b0;
      end
    end
    // A refusal in the same cycle as its clear keeps the flag set.
    refused_nxt = refuse ||
      (refused_r && !(sw_wr && sw_addr == IPB_HOST_STATUS && sw_wdata[IPB_ST_REFUSED]));
    if (sw_rd) begin
      if (sw_addr == IPB_HOST_CTRL) begin
        sw_rdata_nxt = {13'h0000, ctrl_r};
      end else if (sw_addr == IPB_HOST_DEV_WRITE) begin
        sw_rdata_nxt = {8'h00, shadow_r};
      end else if (sw_addr == IPB_HOST_STATUS) begin
        sw_rdata_nxt = {rd_data_r, 5'h00, rd_busy_r, rd_valid_r, refused_r};
      end else begin
        sw_rdata_nxt = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= IPB_HOST_CTRL_RESET;
      shadow_r <= IPB_CFG_RESET;
      refused_r <= 1'b0;
      rd_data_r <= 8'h00;
      rd_valid_r <= 1'b0;
      rd_busy_r <= 1'b0;
      sw_rdata_r <= 16'h0000;
      dev_addr_r <= 8'h00;
      dev_wdata_r <= 8'h00;
      dev_wr_r <= 1'b0;
      dev_rd_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      shadow_r <= shadow_nxt;
      refused_r <= refused_nxt;
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_busy_r <= rd_busy_nxt;
      sw_rdata_r <= sw_rdata_nxt;
      dev_addr_r <= dev_addr_nxt;
      dev_wdata_r <= dev_wdata_nxt;
      dev_wr_r <= dev_wr_nxt;
      dev_rd_r <= dev_rd_nxt;
    end
  end

  //----------------------------------------------------------------------------
  // Bus bit clock, framing and slot data
  //----------------------------------------------------------------------------
  // The bus rate does not divide the system clock evenly, so a phase
  // accumulator spreads the bit enables; each bit lasts 7 or 8 cycles at most speed.
  ipb_speed_t speed;
  logic [16:0] inc;
  logic [17:0] sum;
  logic [16:0] acc_r, acc_nxt;
  logic first_r, first_nxt;
  logic bit_en_r, bit_en_nxt;
  logic sync_r, sync_nxt;
  ipb_idx_t nidx_r, nidx_nxt;
  ipb_idx_t cur_r, cur_nxt;
  logic tx_data_r, tx_data_nxt;
  ipb_byte_t tx_shift_r, tx_shift_nxt;
  logic [7:0] tx_slot_r, tx_slot_nxt;
  ipb_byte_t rx_shift_r, rx_shift_nxt;
  ipb_byte_t rx_byte_r, rx_byte_nxt;
  logic [7:0] rx_slot_r, rx_slot_nxt;
  logic rx_valid_r, rx_valid_nxt;
  logic fstart_r, fstart_nxt;
  logic tsync_out_r, tsync_out_nxt;
  logic tsync_oe_r, tsync_oe_nxt;

  assign speed = ipb_eff_speed(shadow_r);
  assign inc = 17'(IPB_BASE_KHZ) << speed;
  assign sum = {1'b0, acc_r} + {1'b0, inc};

  always_comb begin
    acc_nxt = acc_r;
    first_nxt = first_r;
    bit_en_nxt = 1'b0;
    sync_nxt = 1'b0;
    nidx_nxt = nidx_r;
    cur_nxt = cur_r;
    tx_data_nxt = tx_data_r;
    tx_shift_nxt = tx_shift_r;
    tx_slot_nxt = tx_slot_r;
    rx_shift_nxt = rx_shift_r;
    rx_byte_nxt = rx_byte_r;
    rx_slot_nxt = rx_slot_r;
    rx_valid_nxt = 1'b0;
    if (!ctrl_r[IPB_CTRL_RUN]) begin
      acc_nxt = 17'h00000;
      first_nxt = 1'b1;
      cur_nxt = 11'h000;
      tx_slot_nxt = 8'h00;
    end else if (sum >= 18'(IPB_CLK_KHZ)) begin
      acc_nxt = 17'(sum - 18'(IPB_CLK_KHZ));
      bit_en_nxt = 1'b1;
      first_nxt = 1'b0;
      if (first_r || nidx_r >= ipb_frame_last(speed)) begin
        nidx_nxt = 11'h000;
      end else begin
        nidx_nxt = 11'(nidx_r + 11'h001);
      end
      sync_nxt = (nidx_nxt == 11'h000);
    end else begin
      acc_nxt = sum[16:0];
    end
    if (bit_en_r) begin
      rx_shift_nxt = {rx_shift_r[6:0], link.rx_bus_level};
      if (cur_r[2:0] == 3'h7) begin
        rx_byte_nxt = {rx_shift_r[6:0], link.rx_bus_level};
        rx_slot_nxt = cur_r[10:3];
        rx_valid_nxt = link.rx_bus_oe;
      end
      cur_nxt = nidx_r;
      if (nidx_r[2:0] == 3'h0) begin
        tx_data_nxt = bp_tx_byte[7];
        tx_shift_nxt = {bp_tx_byte[6:0], 1'b0};
        tx_slot_nxt = (nidx_r[10:3] == 8'(ipb_frame_last(speed) >> 3)) ?
          8'h00 : 8'(nidx_r[10:3] + 8'h01);
      end else begin
        tx_data_nxt = tx_shift_r[7];
        tx_shift_nxt = {tx_shift_r[6:0], 1'b0};
      end
    end
    fstart_nxt = bit_en_r && sync_r;
    // External transmit sync only while the device is not interleaving.
    tsync_oe_nxt = ctrl_r[IPB_CTRL_TSYNC] && !shadow_r[IPB_EN_BIT] && !dev_wr_r;
    tsync_out_nxt = tsync_oe_nxt && bit_en_r && sync_r;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_r <= 17'h00000;
      first_r <= 1'b1;
      bit_en_r <= 1'b0;
      sync_r <= 1'b0;
      nidx_r <= 11'h000;
      cur_r <= 11'h000;
      tx_data_r <= 1'b0;
      tx_shift_r <= 8'h00;
      tx_slot_r <= 8'h00;
      rx_shift_r <= 8'h00;
      rx_byte_r <= 8'h00;
      rx_slot_r <= 8'h00;
      rx_valid_r <= 1'b0;
      fstart_r <= 1'b0;
      tsync_out_r <= 1'b0;
      tsync_oe_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      first_r <= first_nxt;
      bit_en_r <= bit_en_nxt;
      sync_r <= sync_nxt;
      nidx_r <= nidx_nxt;
      cur_r <= cur_nxt;
      tx_data_r <= tx_data_nxt;
      tx_shift_r <= tx_shift_nxt;
      tx_slot_r <= tx_slot_nxt;
      rx_shift_r <= rx_shift_nxt;
      rx_byte_r <= rx_byte_nxt;
      rx_slot_r <= rx_slot_nxt;
      rx_valid_r <= rx_valid_nxt;
      fstart_r <= fstart_nxt;
      tsync_out_r <= tsync_out_nxt;
      tsync_oe_r <= tsync_oe_nxt;
    end
  end

  assign link.dev_addr = dev_addr_r;
  assign link.dev_wdata = dev_wdata_r;
  assign link.dev_wr = dev_wr_r;
  assign link.dev_rd = dev_rd_r;
  assign link.bus_bit_en = bit_en_r;
  assign link.bus_frame_sync = sync_r;
  assign link.tx_bus_data = tx_data_r;
  assign link.host_tsync_out = tsync_out_r;
  assign link.host_tsync_oe = tsync_oe_r;
  assign sw_rdata = sw_rdata_r;
  assign bp_tx_slot = tx_slot_r;
  assign bp_rx_byte = rx_byte_r;
  assign bp_rx_slot = rx_slot_r;
  assign bp_rx_valid = rx_valid_r;
  assign bp_frame_start = fstart_r;

endmodule // ipb_host_end

// *** testbench/ipb_monitor.sv ***
`timescale 1ns/1ps
module ipb_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] dev_addr,
  input wire logic [7:0] dev_wdata,
  input wire logic dev_wr,
  input wire logic dev_rd,
  input wire logic [7:0] dev_rdata,
  // Bus and sync pin
  input wire logic bus_bit_en,
  input wire logic bus_frame_sync,
  input wire logic rx_bus_data,
  input wire logic rx_bus_oe,
  input wire logic host_tsync_oe,
  input wire logic dev_tsync_oe
);
  // ----
  // Bus position tracker
  // ----
  logic [7:0] cfg_r;
  logic [7:0] cfg_nxt;
  logic [10:0] idx_r;
  logic [10:0] idx_nxt;
  logic sync_r;
  logic sync_nxt;
  logic [1:0] spd;
  logic [2:0] pos;
  logic own;

  // Tracking is suspended from a config write until the next frame sync.
  always_comb begin
    cfg_nxt = cfg_r;
    idx_nxt = idx_r;
    sync_nxt = sync_r;
    if (dev_wr && dev_addr == 8'h1C) begin
      cfg_nxt = dev_wdata;
      sync_nxt = 1'b0;
    end else if (bus_bit_en && bus_frame_sync) begin
      idx_nxt = 11'h000;
      sync_nxt = 1'b1;
    end else if (bus_bit_en) begin
      idx_nxt = idx_r + 11'h001;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_r <= 8'h00;
      idx_r <= 11'h000;
      sync_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      idx_r <= idx_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign spd = cfg_r[3] ? cfg_r[5:4] : 2'h0;
  assign pos = cfg_r[3] ? cfg_r[2:0] : 3'h0;
  assign own = (idx_r[10:3] & 8'((9'h001 << spd) - 9'h001)) == {5'h00, pos};

  // ----
  // Assertions
  // ----
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence cfg_read;
    dev_rd && dev_addr == 8'h1C;
  endsequence
  sequence bit_pulse;
    bus_bit_en ##1 !bus_bit_en [*6];
  endsequence

  strobe_excl_a:
    assert property (!(dev_wr && dev_rd)) else $error("register strobes overlap");
  rdata_idle_a:
    assert property (!dev_rd |=> dev_rdata == 8'h00) else $error("read data without read");
  cfg_readback_a:
    assert property (cfg_read |=> dev_rdata == {1'b0, cfg_r[6:0]})
      else $error("config read back wrong");
  wr_rsvd_a:
    assert property (dev_wr && dev_addr == 8'h1C |-> !dev_wdata[7])
      else $error("top config bit written as one");
  pos_fit_a:
    assert property (dev_wr && dev_addr == 8'h1C && dev_wdata[3]
      |-> (dev_wdata[2:0] >> dev_wdata[5:4]) == 3'h0) else $error("position outside bus");
  sync_bit_a:
    assert property (bus_frame_sync |-> bus_bit_en) else $error("frame sync off bit");
  bit_space_a:
    assert property (bus_bit_en |-> bit_pulse) else $error("bus bits too close");
  bit_hold_a:
    assert property (sync_r && !bus_bit_en |=> $stable(rx_bus_data) && $stable(rx_bus_oe))
      else $error("bus bit changed inside bit");
  own_slot_a:
    assert property (sync_r && $past(bus_bit_en) |-> rx_bus_oe == own)
      else $error("drive outside own slot");
  tsync_one_a:
    assert property (!(host_tsync_oe && dev_tsync_oe)) else $error("sync pin fight");
  tsync_out_a:
    assert property (sync_r && cfg_r[3] |-> dev_tsync_oe) else $error("sync pin not output");
endmodule // ipb_monitor

// *** testbench/interleaved_pcm_backplane_bus_test.sv ***
`timescale 1ns/1ps
module interleaved_pcm_backplane_bus_test;
  import ipb_pkg::*;
  // ----
  // Signals and instances
  // ----
  logic clk = 1'b0;
  logic reset;
  logic [7:0] sw_addr;
  ipb_word_t sw_wdata;
  logic sw_wr;
  logic sw_rd;
  ipb_word_t sw_rdata;
  ipb_byte_t bp_tx_byte;
  logic [7:0] bp_tx_slot;
  ipb_byte_t bp_rx_byte;
  logic [7:0] bp_rx_slot;
  logic bp_rx_valid;
  ipb_byte_t rx_pcm_byte;
  ipb_chan_t rx_pcm_chan;
  ipb_byte_t tx_pcm_byte;
  ipb_chan_t tx_pcm_chan;
  logic tx_pcm_valid;
  logic pin;
  logic tx_clk_en;
  logic interleave_active;
  logic [4:0] div_r;
  logic [7:0] msk;
  ipb_speed_t ex_spd;
  logic [2:0] ex_pos;
  int n_fail = 0;
  int n_tests = 0;
  int n_be = 0;
  int n_ck = 0;
  int n_pin = 0;
  int n_rx = 0;

  always #4 clk = ~clk;

  ipb_if ipb_if_i ();
  ipb_device_end ipb_device_end_i (.clk(clk), .reset(reset), .link(ipb_if_i),
    .rx_pcm_byte(rx_pcm_byte), .rx_pcm_chan(rx_pcm_chan), .tx_pcm_byte(tx_pcm_byte),
    .tx_pcm_chan(tx_pcm_chan), .tx_pcm_valid(tx_pcm_valid), .tx_frame_start(),
    .tx_line_clk_pin(pin), .tx_clk_en(tx_clk_en), .interleave_active(interleave_active));
  ipb_host_end ipb_host_end_i (.clk(clk), .reset(reset), .link(ipb_if_i),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .bp_tx_byte(bp_tx_byte), .bp_tx_slot(bp_tx_slot),
    .bp_rx_byte(bp_rx_byte), .bp_rx_slot(bp_rx_slot), .bp_rx_valid(bp_rx_valid),
    .bp_frame_start());
  ipb_monitor ipb_monitor_i (.clk(clk), .reset(reset), .dev_addr(ipb_if_i.dev_addr),
    .dev_wdata(ipb_if_i.dev_wdata), .dev_wr(ipb_if_i.dev_wr), .dev_rd(ipb_if_i.dev_rd),
    .dev_rdata(ipb_if_i.dev_rdata), .bus_bit_en(ipb_if_i.bus_bit_en),
    .bus_frame_sync(ipb_if_i.bus_frame_sync), .rx_bus_data(ipb_if_i.rx_bus_data),
    .rx_bus_oe(ipb_if_i.rx_bus_oe), .host_tsync_oe(ipb_if_i.host_tsync_oe),
    .dev_tsync_oe(ipb_if_i.dev_tsync_oe));

  // ----
  // Checks and tasks
  // ----
  task automatic chk16(input ipb_word_t got, input ipb_word_t exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: word %h, want %h", $time, got, exp);
    end
  endtask

  task automatic chk8(input ipb_byte_t got, input ipb_byte_t exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: byte %h, want %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Each slot carries a byte derived from its channel (device) or its slot number (host), so a misplaced slot shows.
  assign msk = 8'((9'h001 << ex_spd) - 9'h001);
  always @(posedge clk) begin
    rx_pcm_byte <= 8'hA0 | {3'h0, rx_pcm_chan};
    bp_tx_byte <= 8'h5A ^ bp_tx_slot;
    div_r <= (div_r == 5'h13) ? 5'h00 : div_r + 5'h01;
    pin <= (div_r == 5'h13) ? ~pin : pin;
    n_pin += (div_r == 5'h13 && pin == 1'b0) ? 1 : 0;
    n_be += (ipb_if_i.bus_bit_en === 1'b1) ? 1 : 0;
    n_ck += (tx_clk_en === 1'b1) ? 1 : 0;
    if (bp_rx_valid === 1'b1) begin
      n_rx++;
      chk8(bp_rx_slot & msk, {5'h00, ex_pos});
      chk8(bp_rx_byte, 8'hA0 | (bp_rx_slot >> ex_spd));
    end
    if (tx_pcm_valid === 1'b1) begin
      chk8(tx_pcm_byte, 8'h5A ^ (({3'h0, tx_pcm_chan} << ex_spd) | {5'h00, ex_pos}));
    end
  end

  task automatic sw_write(input logic [7:0] a, input ipb_word_t d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic sw_read(input logic [7:0] a, output ipb_word_t d);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    @(negedge clk);
    d = sw_rdata;
    @(posedge clk);
  endtask

  task automatic dev_read(input ipb_byte_t a, output ipb_word_t d);
    sw_write(8'h08, {a, 8'h00});
    repeat (3) @(posedge clk);
    sw_read(8'h0C, d);
  endtask

  task automatic s_reset();
    ipb_word_t d;
    reset <= 1'b1;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk8({7'h0, interleave_active}, 8'h00);
    for (int i = 0; i < 5; i++) begin
      sw_read(8'(4 * i), d);
      chk16(d, 16'h0000);
    end
  endtask

  task automatic s_refuse();
    ipb_word_t d;
    sw_write(8'h04, {8'h1C, 8'h08});
    sw_read(8'h0C, d);
    chk16(d, 16'h0001);
    sw_write(8'h0C, 16'h0001);
    sw_write(8'h00, 16'h0002);
    sw_write(8'h04, {8'h1C, 8'h1A});
    sw_read(8'h04, d);
    chk16(d, 16'h0000);
    sw_read(8'h0C, d);
    chk16(d, 16'h0001);
    sw_write(8'h0C, 16'h0001);
    sw_write(8'h04, {8'h1D, 8'hFF});
    dev_read(8'h1D, d);
    chk16(d, 16'h0002);
    dev_read(8'h1C, d);
    chk16(d, 16'h0002);
  endtask

  // Runs the bus with user traffic from both the host and the device; the clock count is checked
  // with a tolerance of one divider step since the window edges are unaligned.
  task automatic s_stream(input ipb_byte_t c, input ipb_speed_t sp, input logic [2:0] ps);
    ipb_word_t d;
    int b0;
    int k0;
    int p0;
    int r0;
    int st;
    int df;
    ex_spd = sp;
    ex_pos = ps;
    sw_write(8'h00, 16'h0006);
    sw_write(8'h04, {8'h1C, c});
    sw_read(8'h04, d);
    chk16(d, {8'h00, c & 8'h7F});
    dev_read(8'h1C, d);
    chk16(d, {c & 8'h7F, 8'h02});
    chk8({7'h0, interleave_active}, {7'h0, c[3]});
    b0 = n_be;
    k0 = n_ck;
    p0 = n_pin;
    r0 = n_rx;
    sw_write(8'h00, 16'h0007);
    repeat (8000) @(posedge clk);
    sw_write(8'h00, 16'h0006);
    repeat (100) @(posedge clk);
    st = c[6] ? (1 << sp) : 1;
    df = c[6] ? (n_ck - k0) * st - (n_be - b0) : (n_ck - k0) - (n_pin - p0);
    chk8({7'h0, df <= st && df >= -st}, 8'h01);
    chk8({7'h0, n_rx > r0}, 8'h01);
  endtask

  // ----
  // Main sequence and watchdog
  // ----
  initial begin
    sw_addr <= 8'h00;
    sw_wdata <= 16'h0000;
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
    rx_pcm_byte <= 8'h00;
    bp_tx_byte <= 8'h00;
    div_r <= 5'h00;
    pin <= 1'b0;
    ex_spd = 2'h0;
    ex_pos = 3'h0;
    s_reset();
    s_refuse();
    s_stream(8'h08, 2'h0, 3'h0);
    s_stream(8'h99, 2'h1, 3'h1);
    s_stream(8'h6B, 2'h2, 3'h3);
    s_stream(8'h3F, 2'h3, 3'h7);
    s_stream(8'h37, 2'h0, 3'h0);
    s_reset();
    end_sim();
  end

  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    end_sim();
  end
endmodule // interleaved_pcm_backplane_bus_test
